// ### rtl/cpms_map.vh
// constants for the program-side addressing block: vectors, sizes, field positions
// assumes inclusion by every design file of the block
// Notes on behaviour
// - sixteen-entry fifteen-bit return stack, separate storage
// - stack overflow/underflow set sticky flags, optional reset
// - two sixteen-bit pointers over one memory space
// - indirect program memory read costs one cycle
// - linear pointer range spans general purpose banks
// - fifteen-bit program counter, fourteen-bit program words
// - program addresses fold into implemented size
// - reset vector zero, interrupt vector four
// - top 128 words low byte high-endurance
// - interrupt saves context to shadows, return restores
// - decoder accepts exactly forty-nine instructions
// - pointer bit fifteen selects program memory, low byte
// - indirect writes never alter program memory
`ifndef CPMS_MAP_VH
`define CPMS_MAP_VH
`define CPMS_PC_W 15
`define CPMS_PW_W 14
`define CPMS_PTR_W 16
`define CPMS_DM_W 12
`define CPMS_STK_DEPTH 16
`define CPMS_STK_IDX_W 4
`define CPMS_RST_VEC 15'h0000
`define CPMS_IRQ_VEC 15'h0004
`define CPMS_PM_WORDS 2048
`define CPMS_HEF_WORDS 128
`define CPMS_PM_SEL_BIT 15
`define CPMS_LIN_BASE 16'h2000
`define CPMS_LIN_TOP_BITS 3'h1
`define CPMS_GPR_PER_BANK 80
`define CPMS_GPR_OFS 7'h20
`define CPMS_LIN_BANKS 32
`define CPMS_NUM_INSTR 49
`define CPMS_CTX_W 32
`endif

// ### rtl/cpms_prog_addr.v
// program counter, return stack, file pointers, indirect access and shadow context
// assumes a flash array on clk_i that presents the word at pm_addr_o in the same cycle
`timescale 1ns/1ns
`include "cpms_map.vh"
module cpms_prog_addr #(
  parameter PM_WORDS = `CPMS_PM_WORDS,
  parameter LIN_BANKS = `CPMS_LIN_BANKS,
  parameter CTX_W = `CPMS_CTX_W
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire pc_inc_i,
  input wire pc_load_i,
  input wire [`CPMS_PC_W-1:0] pc_target_i,
  input wire call_i,
  input wire ret_i,
  input wire irq_enter_i,
  input wire irq_return_i,
  input wire stack_rst_en_i,
  input wire clr_ovf_i,
  input wire clr_unf_i,
  input wire [5:0] instr_index_i,
  input wire instr_valid_i,
  input wire fp_sel_i,
  input wire fp_wr_lo_i,
  input wire fp_wr_hi_i,
  input wire fp_inc_i,
  input wire [7:0] fp_wdata_i,
  input wire ind_rd_i,
  input wire ind_wr_i,
  input wire ind_sel_i,
  input wire [7:0] ind_wdata_i,
  input wire [`CPMS_PW_W-1:0] pm_rdata_i,
  input wire [CTX_W-1:0] ctx_i,
  output reg [`CPMS_PC_W-1:0] pc_o,
  output reg [`CPMS_PC_W-1:0] pm_addr_o,
  output reg high_endurance_area_o,
  output reg stall_o,
  output reg [7:0] ind_rdata_o,
  output reg ind_rvalid_o,
  output reg [`CPMS_DM_W-1:0] dm_addr_o,
  output reg dm_rd_o,
  output reg dm_wr_o,
  output reg [7:0] dm_wdata_o,
  output reg [`CPMS_PTR_W-1:0] file_pointer0_o,
  output reg [`CPMS_PTR_W-1:0] file_pointer1_o,
  output reg stack_overflow_flag_o,
  output reg stack_underflow_flag_o,
  output reg soft_rst_o,
  output reg [CTX_W-1:0] ctx_o,
  output reg ctx_restore_o,
  output reg instr_illegal_o
);
  localparam PC_W = `CPMS_PC_W;
  localparam PTR_W = `CPMS_PTR_W;
  localparam integer PC_MASK_I = PM_WORDS - 1;
  localparam integer HEF_BASE_I = PM_WORDS - `CPMS_HEF_WORDS;
  localparam integer LIN_SIZE_I = LIN_BANKS * `CPMS_GPR_PER_BANK;
  localparam integer GPR_PB_I = `CPMS_GPR_PER_BANK;
  localparam integer NUM_INSTR_I = `CPMS_NUM_INSTR;
  localparam [PC_W-1:0] PC_MASK = PC_MASK_I[PC_W-1:0];
  localparam [PC_W-1:0] HEF_BASE = HEF_BASE_I[PC_W-1:0];
  localparam [12:0] LIN_SIZE = LIN_SIZE_I[12:0];
  localparam [12:0] GPR_PB = GPR_PB_I[12:0];
  localparam [5:0] NUM_INSTR = NUM_INSTR_I[5:0];
  localparam [PC_W-1:0] ONE_PC = 15'h0001;

  reg [PC_W-1:0] pc_ff;
  reg [PTR_W-1:0] fp_ff [0:1];
  reg [PTR_W-1:0] fp_shadow_ff [0:1];
  reg pend_ff;
  reg [PC_W-1:0] nxt_pc;
  reg [PC_W-1:0] nxt_pm_addr;
  wire [PC_W-1:0] stk_top;
  wire stk_ovf;
  wire stk_unf;
  wire do_push = irq_enter_i || call_i;
  wire do_pop = !do_push && (ret_i || irq_return_i);
  wire [PTR_W-1:0] ind_ptr = ind_sel_i ? fp_ff[1] : fp_ff[0];
  wire ind_is_pm = ind_ptr[`CPMS_PM_SEL_BIT];
  wire [12:0] lin_ofs = ind_ptr[12:0];
  wire ind_is_lin = (ind_ptr[15:13] == `CPMS_LIN_TOP_BITS) && (lin_ofs < LIN_SIZE);
  wire ind_is_trad = (ind_ptr[15:12] == 4'h0);
  wire [12:0] lin_bank = lin_ofs / GPR_PB;
  wire [12:0] lin_rem = lin_ofs % GPR_PB;
  wire [`CPMS_DM_W-1:0] lin_addr = {lin_bank[4:0], lin_rem[6:0] + `CPMS_GPR_OFS};
  wire [`CPMS_DM_W-1:0] ind_dm_addr = ind_is_lin ? lin_addr : ind_ptr[`CPMS_DM_W-1:0];
  wire dm_hit = !ind_is_pm && (ind_is_lin || ind_is_trad);
  wire pm_read_start = ind_rd_i && ind_is_pm && !pend_ff;

  cpms_ret_stack #(
    .DEPTH(`CPMS_STK_DEPTH),
    .IDX_W(`CPMS_STK_IDX_W),
    .W(PC_W)
  ) u_stack (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .push_i(do_push),
    .push_data_i(pc_ff),
    .pop_i(do_pop),
    .top_o(stk_top),
    .ovf_o(stk_ovf),
    .unf_o(stk_unf)
  );

  // program counter next value; interrupt entry outranks every other change
  always @* begin
    nxt_pc = pc_ff;
    if (irq_enter_i) begin
      nxt_pc = `CPMS_IRQ_VEC;
    end else if (call_i) begin
      nxt_pc = pc_target_i;
    end else if (ret_i || irq_return_i) begin
      nxt_pc = stk_top;
    end else if (pc_load_i) begin
      nxt_pc = pc_target_i;
    end else if (pc_inc_i && !stall_o && !pm_read_start) begin
      nxt_pc = pc_ff + ONE_PC;
    end
  end

  always @* begin
    if (pm_read_start) begin
      nxt_pm_addr = ind_ptr[PC_W-1:0] & PC_MASK;
    end else begin
      nxt_pm_addr = nxt_pc & PC_MASK;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc_ff <= `CPMS_RST_VEC;
      pc_o <= `CPMS_RST_VEC;
      pm_addr_o <= `CPMS_RST_VEC;
      high_endurance_area_o <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      pc_o <= nxt_pc;
      pm_addr_o <= nxt_pm_addr;
      high_endurance_area_o <= (nxt_pm_addr >= HEF_BASE);
    end
  end

  // program memory reads through a pointer hold the core for one extra cycle
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend_ff <= 1'b0;
      stall_o <= 1'b0;
      ind_rdata_o <= 8'h00;
      ind_rvalid_o <= 1'b0;
    end else begin
      pend_ff <= pm_read_start;
      stall_o <= pm_read_start;
      ind_rvalid_o <= pend_ff;
      if (pend_ff) begin
        ind_rdata_o <= pm_rdata_i[7:0];
      end
    end
  end

  // data memory side; writes aimed at program memory are dropped
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      dm_addr_o <= {`CPMS_DM_W{1'b0}};
      dm_rd_o <= 1'b0;
      dm_wr_o <= 1'b0;
      dm_wdata_o <= 8'h00;
    end else begin
      dm_rd_o <= ind_rd_i && dm_hit;
      dm_wr_o <= ind_wr_i && dm_hit;
      if ((ind_rd_i || ind_wr_i) && dm_hit) begin
        dm_addr_o <= ind_dm_addr;
        dm_wdata_o <= ind_wdata_i;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_fp
      wire sel = (g == 0) ? !fp_sel_i : fp_sel_i;
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          fp_ff[g] <= {PTR_W{1'b0}};
          fp_shadow_ff[g] <= {PTR_W{1'b0}};
        end else begin
          if (irq_enter_i) begin
            fp_shadow_ff[g] <= fp_ff[g];
          end
          if (irq_return_i && !irq_enter_i) begin
            fp_ff[g] <= fp_shadow_ff[g];
          end else if (sel && fp_wr_hi_i) begin
            fp_ff[g] <= {fp_wdata_i, fp_ff[g][7:0]};
          end else if (sel && fp_wr_lo_i) begin
            fp_ff[g] <= {fp_ff[g][15:8], fp_wdata_i};
          end else if (sel && fp_inc_i) begin
            fp_ff[g] <= fp_ff[g] + 16'h0001;
          end
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      file_pointer0_o <= {PTR_W{1'b0}};
      file_pointer1_o <= {PTR_W{1'b0}};
    end else begin
      file_pointer0_o <= fp_ff[0];
      file_pointer1_o <= fp_ff[1];
    end
  end

  // sticky stack fault flags; a new fault wins over a clear in the same cycle
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      stack_overflow_flag_o <= 1'b0;
      stack_underflow_flag_o <= 1'b0;
      soft_rst_o <= 1'b0;
    end else begin
      if (stk_ovf) begin
        stack_overflow_flag_o <= 1'b1;
      end else if (clr_ovf_i) begin
        stack_overflow_flag_o <= 1'b0;
      end
      if (stk_unf) begin
        stack_underflow_flag_o <= 1'b1;
      end else if (clr_unf_i) begin
        stack_underflow_flag_o <= 1'b0;
      end
      soft_rst_o <= stack_rst_en_i && (stk_ovf || stk_unf);
    end
  end

  // shadow copy of the external core registers
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctx_o <= {CTX_W{1'b0}};
      ctx_restore_o <= 1'b0;
    end else begin
      if (irq_enter_i) begin
        ctx_o <= ctx_i;
      end
      ctx_restore_o <= irq_return_i && !irq_enter_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      instr_illegal_o <= 1'b0;
    end else begin
      instr_illegal_o <= instr_valid_i && (instr_index_i >= NUM_INSTR);
    end
  end
endmodule // cpms_prog_addr

// ### rtl/cpms_ret_stack.v
// return-address stack: array storage with a four-bit top index
// assumes push and pop never arrive in the same cycle from the caller
`timescale 1ns/1ns
`include "cpms_map.vh"
module cpms_ret_stack #(
  parameter DEPTH = `CPMS_STK_DEPTH,
  parameter IDX_W = `CPMS_STK_IDX_W,
  parameter W = `CPMS_PC_W
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire push_i,
  input wire [W-1:0] push_data_i,
  input wire pop_i,
  output wire [W-1:0] top_o,
  output wire ovf_o,
  output wire unf_o
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [IDX_W-1:0] sp_ff;
  reg empty_ff;
  wire full = (sp_ff == DEPTH[IDX_W-1:0] - {{(IDX_W-1){1'b0}}, 1'b1}) && !empty_ff;
  wire [IDX_W-1:0] wr_idx = empty_ff ? {IDX_W{1'b0}} : sp_ff + {{(IDX_W-1){1'b0}}, 1'b1};
  assign ovf_o = push_i && full;
  assign unf_o = pop_i && empty_ff;
  assign top_o = mem[sp_ff];
  always @(posedge clk_i) begin
    if (push_i && !full) begin
      mem[wr_idx] <= push_data_i;
    end
  end
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sp_ff <= {IDX_W{1'b0}};
      empty_ff <= 1'b1;
    end else if (push_i && !full) begin
      sp_ff <= wr_idx;
      empty_ff <= 1'b0;
    end else if (pop_i && !empty_ff) begin
      if (sp_ff == {IDX_W{1'b0}}) begin
        empty_ff <= 1'b1;
      end else begin
        sp_ff <= sp_ff - {{(IDX_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // cpms_ret_stack

// ### tb/cpms_flash_model.sv
// flash array model: a fixed word pattern at every address, same-cycle read
// assumes the block presents a folded address and samples the word on its own clock
`timescale 1ns/1ns
module cpms_flash_model (
  input wire [14:0] addr_i,
  output wire [13:0] rdata_o
);
  // fourteen-bit words, pattern differs between neighbouring addresses
  assign rdata_o = {addr_i[5:0], addr_i[7:0]} ^ 14'h2A5C;
endmodule // cpms_flash_model

// ### tb/cpms_prog_addr_props.sv
// port checker for the program addressing block
// assumes a bind onto cpms_prog_addr with one clock and synchronous reset
`timescale 1ns/1ns
module cpms_prog_addr_props #(parameter PM_WORDS = 2048) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire call_i,
  input wire irq_enter_i,
  input wire [14:0] pc_target_i,
  input wire stack_rst_en_i,
  input wire clr_ovf_i,
  input wire [5:0] instr_index_i,
  input wire instr_valid_i,
  input wire [13:0] pm_rdata_i,
  input wire [31:0] ctx_i,
  input wire [14:0] pc_o,
  input wire [14:0] pm_addr_o,
  input wire high_endurance_area_o,
  input wire stall_o,
  input wire [7:0] ind_rdata_o,
  input wire ind_rvalid_o,
  input wire stack_overflow_flag_o,
  input wire soft_rst_o,
  input wire [31:0] ctx_o,
  input wire instr_illegal_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence pm_fetch_s; stall_o && !ind_rvalid_o; endsequence
  sequence pm_done_s; ind_rvalid_o && !stall_o; endsequence
  call_target_a: assert property (call_i && !irq_enter_i |=> pc_o == $past(pc_target_i))
    else $error("call target not loaded");
  irq_vector_a: assert property (irq_enter_i |=> pc_o == 15'h0004)
    else $error("interrupt vector wrong");
  addr_fold_a: assert property (!stall_o |-> pm_addr_o == (pc_o & (PM_WORDS - 1)))
    else $error("program address not folded");
  endurance_area_a: assert property (high_endurance_area_o == (pm_addr_o >= PM_WORDS - 128))
    else $error("endurance area flag wrong");
  pm_read_a: assert property (pm_fetch_s |=> pm_done_s ##0 ind_rdata_o == $past(pm_rdata_i[7:0]))
    else $error("program memory read wrong");
  ovf_reset_a: assert property ($rose(stack_overflow_flag_o) && $past(stack_rst_en_i) |-> soft_rst_o)
    else $error("no soft reset on overflow");
  ovf_sticky_a: assert property (stack_overflow_flag_o && !clr_ovf_i |=> stack_overflow_flag_o)
    else $error("overflow flag lost");
  illegal_op_a: assert property (instr_valid_i |=> instr_illegal_o == ($past(instr_index_i) >= 6'd49))
    else $error("illegal flag wrong");
  ctx_save_a: assert property (irq_enter_i |=> ctx_o == $past(ctx_i))
    else $error("context not saved");
endmodule // cpms_prog_addr_props
bind cpms_prog_addr cpms_prog_addr_props #(.PM_WORDS(PM_WORDS)) u_props (.*);

// ### tb/test_cpms_prog_addr.sv
// self-checking bench for the program addressing block with a flash model
// assumes the checker is bound from its own file
`timescale 1ns/1ns
module test_cpms_prog_addr;
  reg clk_i = 0, sys_rst_i = 1, pc_inc_i = 0, pc_load_i = 0, call_i = 0, ret_i = 0;
  reg irq_enter_i = 0, irq_return_i = 0, stack_rst_en_i = 0, clr_ovf_i = 0, clr_unf_i = 0;
  reg instr_valid_i = 0, fp_sel_i = 0, fp_wr_lo_i = 0, fp_wr_hi_i = 0, fp_inc_i = 0;
  reg ind_rd_i = 0, ind_wr_i = 0, ind_sel_i = 0;
  reg [14:0] pc_target_i = 0;
  reg [5:0] instr_index_i = 0;
  reg [7:0] fp_wdata_i = 0, ind_wdata_i = 0;
  reg [31:0] ctx_i = 0;
  wire [14:0] pc_o, pm_addr_o;
  wire [13:0] pm_rdata_i;
  wire [7:0] ind_rdata_o, dm_wdata_o;
  wire [11:0] dm_addr_o;
  wire [15:0] file_pointer0_o, file_pointer1_o;
  wire [31:0] ctx_o;
  wire high_endurance_area_o, stall_o, ind_rvalid_o, dm_rd_o, dm_wr_o, stack_overflow_flag_o;
  wire stack_underflow_flag_o, soft_rst_o, ctx_restore_o, instr_illegal_o;
  integer mismatches = 0, cmp_count = 0, cycles = 0, i;
  reg [14:0] saved [0:15];
  cpms_prog_addr #(.PM_WORDS(2048)) uut (.*);
  cpms_flash_model flash (.addr_i(pm_addr_o), .rdata_o(pm_rdata_i));
  always #4 clk_i = ~clk_i;
  task wrap_up;
    $display("%0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one clock, then drop every pulse input
  task step;
    @(negedge clk_i);
    {pc_inc_i, pc_load_i, call_i, ret_i, irq_enter_i, irq_return_i, clr_ovf_i, clr_unf_i,
      instr_valid_i, fp_wr_lo_i, fp_wr_hi_i, fp_inc_i, ind_rd_i, ind_wr_i} = 14'h0000;
  endtask
  // one clock with every input left standing, for back-to-back pulses
  task step_hold;
    @(negedge clk_i);
  endtask
  task do_reset;
    sys_rst_i = 1;
    repeat (8) step;
    sys_rst_i = 0;
    chk(pc_o, 15'h0000);
    chk({stack_overflow_flag_o, stack_underflow_flag_o}, 2'h0);
  endtask
  task t_pc;
    pc_target_i = 15'h0805;
    call_i = 1;
    step;
    chk(pc_o, 15'h0805);
    chk(pm_addr_o, 15'h0005);
    pc_inc_i = 1;
    step;
    chk(pc_o, 15'h0806);
    ctx_i = 32'hA5C30F1E;
    irq_enter_i = 1;
    step;
    chk(pc_o, 15'h0004);
    chk(ctx_o, 32'hA5C30F1E);
    irq_return_i = 1;
    step;
    chk(pc_o, 15'h0806);
    chk(ctx_restore_o, 1'h1);
    ret_i = 1;
    step;
    chk(pc_o, 15'h0000);
    pc_target_i = 15'h07F0;
    pc_load_i = 1;
    step_hold;
    chk(high_endurance_area_o, 1'h1);
    pc_target_i = 15'h077F;
    pc_load_i = 1;
    step;
    chk(high_endurance_area_o, 1'h0);
    $display("pc test done");
  endtask
  task t_stack;
    do_reset;
    stack_rst_en_i = 1;
    for (i = 0; i < 16; i = i + 1) begin
      saved[i] = pc_o;
      pc_target_i = i + 1;
      call_i = 1;
      step_hold;
    end
    chk(stack_overflow_flag_o, 1'h0);
    pc_target_i = 15'h0100;
    call_i = 1;
    step;
    chk(stack_overflow_flag_o, 1'h1);
    chk(soft_rst_o, 1'h1);
    step;
    chk(soft_rst_o, 1'h0);
    for (i = 15; i >= 0; i = i - 1) begin
      ret_i = 1;
      step_hold;
      chk(pc_o, saved[i]);
    end
    chk(stack_underflow_flag_o, 1'h0);
    ret_i = 1;
    step;
    chk(stack_underflow_flag_o, 1'h1);
    clr_ovf_i = 1;
    clr_unf_i = 1;
    step;
    chk({stack_overflow_flag_o, stack_underflow_flag_o}, 2'h0);
    stack_rst_en_i = 0;
    $display("stack test done");
  endtask
  task t_ind;
    fp_wr_hi_i = 1;
    fp_wdata_i = 8'h81;
    step;
    fp_wr_lo_i = 1;
    fp_wdata_i = 8'h23;
    step;
    ind_rd_i = 1;
    step;
    chk(stall_o, 1'h1);
    chk(pm_addr_o, 15'h0123);
    chk(dm_rd_o, 1'h0);
    chk(file_pointer0_o, 16'h8123);
    step;
    chk(ind_rvalid_o, 1'h1);
    // low byte of the model word at 0x123: 0x23 xor 0x5C
    chk(ind_rdata_o, 8'h7F);
    ind_wr_i = 1;
    ind_wdata_i = 8'h3C;
    step;
    chk(dm_wr_o, 1'h0);
    step;
    chk(dm_wr_o, 1'h0);
    fp_sel_i = 1;
    fp_wr_hi_i = 1;
    fp_wdata_i = 8'h20;
    step;
    fp_wr_lo_i = 1;
    fp_wdata_i = 8'h4F;
    step;
    fp_inc_i = 1;
    step;
    step;
    chk(file_pointer1_o, 16'h2050);
    ind_sel_i = 1;
    ind_wr_i = 1;
    step;
    chk(dm_wr_o, 1'h1);
    chk(dm_addr_o, 12'h0A0);
    chk(dm_wdata_o, 8'h3C);
    ind_rd_i = 1;
    step;
    chk(dm_rd_o, 1'h1);
    chk(dm_addr_o, 12'h0A0);
    // pointer shadow: save on entry, overwrite, restore on return
    irq_enter_i = 1;
    step;
    fp_wr_hi_i = 1;
    fp_wdata_i = 8'h00;
    step;
    irq_return_i = 1;
    step;
    chk(file_pointer1_o, 16'h0050);
    step;
    chk(file_pointer1_o, 16'h2050);
    $display("indirect test done");
  endtask
  task t_instr;
    for (i = 47; i < 51; i = i + 1) begin
      instr_index_i = i;
      instr_valid_i = 1;
      step_hold;
      chk(instr_illegal_o, i > 48);
    end
    instr_valid_i = 0;
    $display("instruction test done");
  endtask
  initial begin
    do_reset;
    t_pc;
    t_stack;
    t_ind;
    t_instr;
    wrap_up;
  end
endmodule // test_cpms_prog_addr
